/* common/ufcam_pkg.sv */
// Package for the serial receive checker with frame check and address match.
// Assumes one 200 MHz clock and an AXI4-Lite register slave.
package ufcam_pkg;

    // Byte addresses of the register words.
    localparam logic [7:0] ADDR_SCTRL = 8'h00;
    localparam logic [7:0] ADDR_PCTRL = 8'h04;
    localparam logic [7:0] ADDR_NADDR = 8'h08;
    localparam logic [7:0] ADDR_NMASK = 8'h0C;
    localparam logic [7:0] ADDR_RXDAT = 8'h10;
    localparam logic [7:0] ADDR_DIV = 8'h14;
    localparam logic [7:0] ADDR_ISTAT = 8'h18;
    localparam logic [7:0] ADDR_IMASK = 8'h1C;

    // Field positions in the serial control register.
    localparam int BIT_FEMODE = 7;
    localparam int BIT_MODELO = 6;
    localparam int BIT_FILTER = 5;
    localparam int BIT_RXEN = 4;
    localparam int BIT_NINTH = 2;
    localparam int BIT_RXDONE = 0;
    // Field position in the power control register.
    localparam int BIT_FESEL = 6;

    // Values after reset.
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_DIV = 16'h006C;

    // Samples per bit; a bit is sampled in the middle.
    localparam int OVERSAMPLE = 16;
    localparam logic [3:0] MID_SAMPLE = 4'h7;
    localparam logic [3:0] LAST_SAMPLE = 4'hF;

    // Receiver states, Gray coded along the frame.
    typedef enum logic [2:0] {
        RX_IDLE = 3'b000,
        RX_START = 3'b001,
        RX_DATA = 3'b011,
        RX_NINTH = 3'b010,
        RX_STOP = 3'b110
    } ufcam_rxst_t;

    // A finished frame as handed from the receiver.
    typedef struct packed {
        logic [7:0] data;
        logic ninth;
        logic stopOk;
        logic nine;
    } ufcam_frame_t;

endpackage

/* rtl/ufcam_addr_match.sv */
// Address comparator for the multiprocessor filter.
// Assumes its inputs are stable registers on the same clock.
module ufcam_addr_match
    import ufcam_pkg::*;
(
    // Received address and node settings.
    input wire logic [7:0] rxAddr,
    input wire logic [7:0] nodeAddress,
    input wire logic [7:0] nodeMask,
    // Match result.
    output logic hit
);

    logic [7:0] bcastCare;
    logic givenHit;
    logic bcastHit;

    // Mask zeros are don't-care for the given address.
    assign givenHit = ((rxAddr ^ nodeAddress) & nodeMask) == 8'h00;
    // Broadcast pattern is the OR, its zeros are don't-care.
    assign bcastCare = nodeAddress | nodeMask;
    assign bcastHit = ((rxAddr ^ bcastCare) & bcastCare) == 8'h00;
    assign hit = givenHit | bcastHit;

endmodule

/* rtl/ufcam_top.sv */
// Serial receiver with framing check and automatic address recognition.
// Assumes an AXI4-Lite master on clk_sys and an asynchronous rxd pin.
//
// Chosen here: the AXI4-Lite slave port and the register addresses.
module ufcam_top
    import ufcam_pkg::*;
#(
    parameter int DIV_W = 16
)
(
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rstn,
    // AXI4-Lite write channels.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels.
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Serial line and interrupt.
    input wire logic rxd,
    output logic irq
);

    // Register state.
    logic feFlag_q, modeHigh_q, modeLow_q, filterEn_q, rxEn_q;
    logic ninthBit_q, rxDone_q, feSel_q, smod1_q;
    logic [7:0] nodeAddr_q, nodeMask_q, rxData_q;
    logic [DIV_W-1:0] div_q;
    logic [1:0] istat_q, imask_q;
    // Bus handshake state.
    logic awHeld_q, wHeld_q, bValid_q, rValid_q, wStrbLo_q;
    logic [7:0] awAddr_q;
    logic [31:0] wData_q, rData_q;
    logic [1:0] bResp_q, rResp_q;
    // Receiver state.
    ufcam_rxst_t st_q;
    logic [DIV_W-1:0] divCnt_q;
    logic [3:0] sampCnt_q;
    logic [2:0] bitCnt_q;
    logic [7:0] shift_q;
    logic ninthRx_q;
    logic rxdMeta_q, rxdSync_q, rxdPrev_q;

    // Two-stage synchroniser for the asynchronous line.
    // A third flop keeps the previous level for start-edge detection; it
    // resets to the idle level so that no false edge follows reset.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rxdMeta_q <= 1'b1;
            rxdSync_q <= 1'b1;
            rxdPrev_q <= 1'b1;
        end else begin
            rxdMeta_q <= rxd;
            rxdSync_q <= rxdMeta_q;
            rxdPrev_q <= rxdSync_q;
        end
    end

    // Oversample tick: one-cycle enable at 16 times the baud rate.
    logic tick;
    assign tick = (divCnt_q == '0);
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) divCnt_q <= '0;
        else if (tick) divCnt_q <= div_q;
        else divCnt_q <= divCnt_q - 1'b1;
    end

    // Mode decode: mode 0 is the shift mode and has no filter.
    logic [1:0] mode;
    logic asyncMode, nineBits, filterOn, feOn;
    assign mode = {modeHigh_q, modeLow_q};
    assign asyncMode = (mode != 2'b00);
    assign nineBits = mode[1];
    assign filterOn = filterEn_q & asyncMode;
    assign feOn = feSel_q & asyncMode;

    // Receiver sequencing on the sample tick.
    logic midBit, lastSamp, rxLow, rxFall;
    assign midBit = tick && (sampCnt_q == MID_SAMPLE);
    assign lastSamp = tick && (sampCnt_q == LAST_SAMPLE);
    assign rxLow = !rxdSync_q;
    // Only a falling edge starts a frame, so a low stop bit cannot restart.
    assign rxFall = rxdPrev_q && rxLow;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st_q <= RX_IDLE;
            sampCnt_q <= '0;
            bitCnt_q <= '0;
            shift_q <= RST_BYTE;
            ninthRx_q <= 1'b0;
        end else begin
            if (tick) sampCnt_q <= sampCnt_q + 4'h1;
            case (st_q)
                RX_IDLE: begin
                    sampCnt_q <= '0;
                    if (rxFall && rxEn_q && asyncMode) st_q <= RX_START;
                end
                RX_START: begin
                    if (midBit && !rxLow) st_q <= RX_IDLE;
                    else if (lastSamp) begin
                        st_q <= RX_DATA;
                        bitCnt_q <= '0;
                    end
                end
                RX_DATA: begin
                    if (midBit) shift_q <= {rxdSync_q, shift_q[7:1]};
                    if (lastSamp) begin
                        bitCnt_q <= bitCnt_q + 3'h1;
                        if (bitCnt_q == 3'h7) begin
                            st_q <= nineBits ? RX_NINTH : RX_STOP;
                        end
                    end
                end
                RX_NINTH: begin
                    if (midBit) ninthRx_q <= rxdSync_q;
                    if (lastSamp) st_q <= RX_STOP;
                end
                RX_STOP: begin
                    if (midBit) st_q <= RX_IDLE;
                end
                default: st_q <= RX_IDLE;
            endcase
        end
    end

    // Frame completion: the stop bit is sampled in mid-bit.
    logic frameEnd, stopOk, addrBit, addrHit, accept;
    assign frameEnd = (st_q == RX_STOP) && midBit;
    assign stopOk = rxdSync_q;
    // Mode 1 with filter: the stop bit plays the ninth bit.
    assign addrBit = nineBits ? ninthRx_q : stopOk;
    // Filtered frames with a zero ninth bit are dropped.
    assign accept = !filterOn || (addrBit && addrHit)
        && (nineBits || stopOk);

    ufcam_addr_match u_match (
        .rxAddr(shift_q),
        .nodeAddress(nodeAddr_q),
        .nodeMask(nodeMask_q),
        .hit(addrHit)
    );

    // Completion events for the flags; both land on the stop bit.
    logic rxEvent, feEvent;
    assign rxEvent = frameEnd && accept;
    assign feEvent = frameEnd && feOn && !stopOk;

    // Bus decode for writes and reads.
    logic wrFire, rdFire;
    logic [7:0] wByte;
    assign wrFire = awHeld_q && wHeld_q && !bValid_q;
    assign rdFire = s_axi_arvalid && !rValid_q;
    assign wByte = wData_q[7:0];
    assign s_axi_awready = !awHeld_q;
    assign s_axi_wready = !wHeld_q;
    assign s_axi_arready = !rValid_q;
    assign s_axi_bvalid = bValid_q;
    assign s_axi_bresp = bResp_q;
    assign s_axi_rvalid = rValid_q;
    assign s_axi_rdata = rData_q;
    assign s_axi_rresp = rResp_q;

    logic wSctrl, wPctrl, wNaddr, wNmask, wDiv, wIstat, wImask, wLane0;
    logic wMapped;
    assign wLane0 = wrFire && wStrbLo_q;
    assign wSctrl = wLane0 && (awAddr_q == ADDR_SCTRL);
    assign wPctrl = wLane0 && (awAddr_q == ADDR_PCTRL);
    assign wNaddr = wLane0 && (awAddr_q == ADDR_NADDR);
    assign wNmask = wLane0 && (awAddr_q == ADDR_NMASK);
    assign wDiv = wLane0 && (awAddr_q == ADDR_DIV);
    assign wIstat = wLane0 && (awAddr_q == ADDR_ISTAT);
    assign wImask = wLane0 && (awAddr_q == ADDR_IMASK);
    assign wMapped = (awAddr_q == ADDR_SCTRL) || (awAddr_q == ADDR_PCTRL)
        || (awAddr_q == ADDR_NADDR) || (awAddr_q == ADDR_NMASK)
        || (awAddr_q == ADDR_RXDAT) || (awAddr_q == ADDR_DIV)
        || (awAddr_q == ADDR_ISTAT) || (awAddr_q == ADDR_IMASK);

    // Bit 7 of the control word targets the flag or the mode bit.
    logic wrFe, wrModeHigh;
    assign wrFe = wSctrl && feSel_q;
    assign wrModeHigh = wSctrl && !feSel_q;

    // Write channel capture and response.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            bValid_q <= 1'b0;
            awAddr_q <= '0;
            wData_q <= '0;
            bResp_q <= 2'b00;
            wStrbLo_q <= 1'b0;
        end else begin
            if (s_axi_awvalid && !awHeld_q) begin
                awHeld_q <= 1'b1;
                awAddr_q <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && !wHeld_q) begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrbLo_q <= s_axi_wstrb[0];
            end
            if (wrFire) begin
                awHeld_q <= 1'b0;
                wHeld_q <= 1'b0;
                bValid_q <= 1'b1;
                bResp_q <= wMapped ? 2'b00 : 2'b10;
            end else if (bValid_q && s_axi_bready) bValid_q <= 1'b0;
        end
    end

    // Control fields; hardware sets of the flags win over clears.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            {feFlag_q, modeHigh_q, modeLow_q, filterEn_q} <= 4'h0;
            {rxEn_q, ninthBit_q, rxDone_q, feSel_q, smod1_q} <= 5'h00;
            nodeAddr_q <= RST_BYTE;
            nodeMask_q <= RST_BYTE;
            rxData_q <= RST_BYTE;
            div_q <= DIV_W'(RST_DIV);
        end else begin
            if (wSctrl) begin
                modeLow_q <= wByte[BIT_MODELO];
                filterEn_q <= wByte[BIT_FILTER];
                rxEn_q <= wByte[BIT_RXEN];
                ninthBit_q <= wByte[BIT_NINTH];
                rxDone_q <= wByte[BIT_RXDONE];
            end
            if (wrModeHigh) modeHigh_q <= wByte[BIT_FEMODE];
            if (wrFe) feFlag_q <= wByte[BIT_FEMODE];
            if (feEvent) feFlag_q <= 1'b1;
            if (rxEvent) begin
                rxDone_q <= 1'b1;
                rxData_q <= shift_q;
                if (nineBits) ninthBit_q <= ninthRx_q;
            end
            if (wPctrl) begin
                feSel_q <= wByte[BIT_FESEL];
                smod1_q <= wByte[7];
            end
            if (wNaddr) nodeAddr_q <= wByte;
            if (wNmask) nodeMask_q <= wByte;
            if (wDiv) div_q <= DIV_W'(wData_q);
        end
    end

    // Interrupt status: bit 0 receive, bit 1 framing error.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            istat_q <= 2'b00;
            imask_q <= 2'b00;
        end else begin
            istat_q <= (istat_q & ~(wIstat ? wByte[1:0] : 2'b00))
                | {feEvent, rxEvent};
            if (wImask) imask_q <= wByte[1:0];
        end
    end
    assign irq = |(istat_q & imask_q);

    // Read data multiplexer.
    logic [7:0] sctrlView;
    logic [31:0] rdMux;
    logic rdMapped;
    assign sctrlView = {feSel_q ? feFlag_q : modeHigh_q, modeLow_q,
        filterEn_q, rxEn_q, 1'b0, ninthBit_q, 1'b0, rxDone_q};
    always_comb begin
        rdMux = '0;
        rdMapped = 1'b1;
        case ({s_axi_araddr[7:2], 2'b00})
            ADDR_SCTRL: rdMux[7:0] = sctrlView;
            ADDR_PCTRL: rdMux[7:6] = {smod1_q, feSel_q};
            ADDR_NADDR: rdMux[7:0] = nodeAddr_q;
            ADDR_NMASK: rdMux[7:0] = nodeMask_q;
            ADDR_RXDAT: rdMux[7:0] = rxData_q;
            ADDR_DIV: rdMux[DIV_W-1:0] = div_q;
            ADDR_ISTAT: rdMux[1:0] = istat_q;
            ADDR_IMASK: rdMux[1:0] = imask_q;
            default: rdMapped = 1'b0;
        endcase
    end

    // Read response register.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rValid_q <= 1'b0;
            rData_q <= '0;
            rResp_q <= 2'b00;
        end else if (rdFire) begin
            rValid_q <= 1'b1;
            rData_q <= rdMux;
            rResp_q <= rdMapped ? 2'b00 : 2'b10;
        end else if (rValid_q && s_axi_rready) rValid_q <= 1'b0;
    end

    // Checks on the flag behaviour.
    fe_sticky_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        feFlag_q && !wrFe |=> feFlag_q)
        else $error("Framing flag dropped without a write.");
    fe_set_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        feEvent |=> feFlag_q)
        else $error("Bad stop bit did not set the framing flag.");
    fe_gate_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        !feSel_q |-> !feEvent)
        else $error("Framing check ran while deselected.");
    rx_filter_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        frameEnd && filterOn && nineBits && !ninthRx_q |-> !rxEvent)
        else $error("Data frame passed the filter.");
    rx_addr_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        rxEvent && filterOn |-> addrHit)
        else $error("Unmatched address raised receive flag.");
    rx_stop_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        rxEvent |-> st_q == RX_STOP)
        else $error("Receive flag not raised at stop bit.");
    mode0_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        mode == 2'b00 |-> !filterOn)
        else $error("Filter active in shift mode.");
    ninth_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        rxEvent && nineBits |=> ninthBit_q == $past(ninthRx_q))
        else $error("Ninth bit not stored.");
    m1_stop_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        rxEvent && filterOn && !nineBits |-> stopOk)
        else $error("Mode 1 address accepted without stop bit.");
    irq_lvl_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        irq == |(istat_q & imask_q))
        else $error("Interrupt level mismatch.");
    cov_fe_c: cover property (@(posedge clk_sys) disable iff (!rstn) feEvent);
    cov_addr_c: cover property (@(posedge clk_sys) disable iff (!rstn)
        rxEvent && filterOn);
    cov_drop_c: cover property (@(posedge clk_sys) disable iff (!rstn)
        frameEnd && !accept);
    cov_ninth_c: cover property (@(posedge clk_sys) disable iff (!rstn)
        rxEvent && nineBits && ninthRx_q);

endmodule

/* verif/ufcam_line_model.sv */
// Far node model that sends frames on the receive pin.
// Assumes the bench sets the bit time to match the divider it writes.
module ufcam_line_model #(
    parameter int BITC = 32
)
(
    // Clock.
    input wire logic clk,
    // Serial line, idle high.
    output logic rxd
);
    timeunit 1ns;
    timeprecision 1ps;

    // The line idles high between frames.
    initial rxd = 1'h1;

    // Holds one bit on the line for a whole bit time.
    task automatic bitOut(input logic b);
        rxd <= b;
        repeat (BITC) @(posedge clk);
    endtask

    // Sends start, eight data bits LSB first, optional ninth, stop.
    task automatic send(input logic [7:0] d, input logic nine,
                        input logic ninth, input logic stp);
        bitOut(1'h0);
        for (int i = 0; i < 8; i++) begin
            bitOut(d[i]);
        end
        if (nine) begin
            bitOut(ninth);
        end
        bitOut(stp);
        rxd <= 1'h1;
    endtask
endmodule

/* verif/tb_top.sv */
// Self-checking bench for the receiver with frame check and address match.
// Assumes divider value 1, so one bit lasts 32 clocks.
module tb_top
    import ufcam_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // Clock, reset and bus signals.
    logic clk_sys = 1'h0;
    logic rstn = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h0;
    logic [7:0] s_axi_araddr = 8'h0;
    logic s_axi_awvalid = 1'h0;
    logic s_axi_wvalid = 1'h0;
    logic s_axi_arvalid = 1'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_bready = 1'h1;
    logic s_axi_rready = 1'h1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, rxd, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [31:0] s_axi_rdata, s;
    logic nineOn = 1'h0;
    int errors = 0;
    int nTests = 0;

    // Clock at 200 MHz.
    always #2.5 clk_sys = ~clk_sys;

    ufcam_top #(.DIV_W(16)) dut_u (
        .clk_sys, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .rxd, .irq
    );

    ufcam_line_model #(.BITC(32)) line_u (.clk(clk_sys), .rxd(rxd));

    // Prints the verdict and ends the run.
    task automatic close_out;
        if (errors == 0 && nTests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Compares one value and counts it.
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        nTests++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Writes one word; address and data are offered together.
    task automatic axw(input logic [7:0] a, input logic [31:0] d,
                       output logic [1:0] r);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do begin
            @(posedge clk_sys);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid && n < 200);
        r = s_axi_bresp;
        if (n >= 200) errors++;
    endtask

    // Reads one word and its response code.
    task automatic axr(input logic [7:0] a, output logic [31:0] d,
                       output logic [1:0] r);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do begin
            @(posedge clk_sys);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid && n < 200);
        d = s_axi_rdata;
        r = s_axi_rresp;
        if (n >= 200) errors++;
    endtask

    // Sets control, clears flags, sends a frame, checks control bits.
    task automatic fc(input logic [7:0] sc, input logic nin,
                      input logic [7:0] d, input logic stp,
                      input logic [7:0] m, input logic [7:0] e);
        axw(ADDR_SCTRL, {24'h0, sc}, rs);
        axw(ADDR_ISTAT, 32'h3, rs);
        line_u.send(d, nineOn, nin, stp);
        repeat (8) @(posedge clk_sys);
        axr(ADDR_SCTRL, s, rs);
        chk("sctrl", {24'h0, e}, s & {24'h0, m});
    endtask

    // Cuts a hang short well beyond the expected run length.
    initial begin
        repeat (40000) @(posedge clk_sys);
        errors++;
        close_out;
    end

    // Main sequence.
    initial begin
        repeat (12) @(posedge clk_sys);
        rstn <= 1'h1;
        @(posedge clk_sys);
        // Reset values of the map, then an unmapped place.
        for (int i = 0; i < 8; i++) begin
            axr(8'(i * 4), s, rs);
            chk("reset", (i == 5) ? {16'h0, RST_DIV} : 32'h0, s);
        end
        axr(8'h20, s, rs);
        chk("rresp", 32'h2, {30'h0, rs});
        axw(8'h20, 32'h1, rs);
        chk("bresp", 32'h2, {30'h0, rs});
        axw(ADDR_DIV, 32'h1, rs);
        // The old divider count runs out before the new rate starts.
        repeat (int'(RST_DIV) + 2) @(posedge clk_sys);
        axw(ADDR_IMASK, 32'h3, rs);
        axw(ADDR_PCTRL, 32'h40, rs);
        // Mode 1 with the frame check: a good frame and its interrupt.
        fc(8'h50, 1'h0, 8'hA5, 1'h1, 8'h81, 8'h01);
        axr(ADDR_RXDAT, s, rs);
        chk("rxdata", 32'hA5, s);
        chk("irq", 32'h1, {31'h0, irq});
        axw(ADDR_ISTAT, 32'h1, rs);
        chk("irq", 32'h0, {31'h0, irq});
        // A bad stop bit, then a good frame that must not clear it.
        fc(8'h50, 1'h0, 8'h3C, 1'h0, 8'h80, 8'h80);
        line_u.send(8'h0F, 1'h0, 1'h0, 1'h1);
        axr(ADDR_SCTRL, s, rs);
        chk("fe sticky", 32'h80, s & 32'h80);
        axr(ADDR_ISTAT, s, rs);
        chk("istat", 32'h3, s);
        axw(ADDR_IMASK, 32'h0, rs);
        chk("irq masked", 32'h0, {31'h0, irq});
        axw(ADDR_IMASK, 32'h2, rs);
        chk("irq fe", 32'h1, {31'h0, irq});
        axw(ADDR_IMASK, 32'h3, rs);
        // Software clears the error flag through bit 7.
        fc(8'h50, 1'h0, 8'h11, 1'h1, 8'h81, 8'h01);
        // Check off: no error is raised and bit 7 reads the mode.
        axw(ADDR_PCTRL, 32'h0, rs);
        fc(8'h50, 1'h0, 8'h22, 1'h0, 8'h80, 8'h00);
        axr(ADDR_ISTAT, s, rs);
        chk("istat fe", 32'h0, s & 32'h2);
        // Mode 3 stores the ninth bit.
        nineOn = 1'h1;
        fc(8'hD0, 1'h1, 8'h33, 1'h1, 8'h05, 8'h05);
        fc(8'hD0, 1'h0, 8'h33, 1'h1, 8'h05, 8'h01);
        // Modes 3 and 2 filter with given and broadcast addresses, mode 3 also unfiltered.
        axw(ADDR_NADDR, 32'h56, rs);
        axw(ADDR_NMASK, 32'hFC, rs);
        fc(8'hF0, 1'h1, 8'h57, 1'h1, 8'h01, 8'h01);
        fc(8'hF0, 1'h1, 8'h5A, 1'h1, 8'h01, 8'h00);
        fc(8'hF0, 1'h1, 8'hFF, 1'h1, 8'h01, 8'h01);
        fc(8'hF0, 1'h1, 8'hFE, 1'h1, 8'h01, 8'h01);
        fc(8'hF0, 1'h1, 8'h7E, 1'h1, 8'h01, 8'h00);
        fc(8'hF0, 1'h0, 8'h57, 1'h1, 8'h01, 8'h00);
        fc(8'hD0, 1'h1, 8'h5A, 1'h1, 8'h01, 8'h01);
        fc(8'hB0, 1'h1, 8'hFE, 1'h1, 8'h01, 8'h01);
        fc(8'hB0, 1'h1, 8'h5A, 1'h1, 8'h01, 8'h00);
        // A full mask leaves only the exact address and the all-ones broadcast.
        axw(ADDR_NMASK, 32'hFF, rs);
        fc(8'hF0, 1'h1, 8'h57, 1'h1, 8'h01, 8'h00);
        fc(8'hF0, 1'h1, 8'h56, 1'h1, 8'h01, 8'h01);
        // Mode 1 filter: the stop bit stands in for the ninth bit.
        nineOn = 1'h0;
        axw(ADDR_NMASK, 32'hFC, rs);
        fc(8'h70, 1'h0, 8'h55, 1'h1, 8'h01, 8'h01);
        fc(8'h70, 1'h0, 8'h55, 1'h0, 8'h01, 8'h00);
        fc(8'h70, 1'h0, 8'h6A, 1'h1, 8'h01, 8'h00);
        // Shift mode: the filter bit has no effect and nothing is taken.
        fc(8'h30, 1'h0, 8'h55, 1'h1, 8'h01, 8'h00);
        close_out;
    end
endmodule
